// file: bench/bku_bp_asserts.sv
// Port-level assertions for the breakpoint unit
`timescale 1ns/100ps
module bku_bp_asserts #(
    parameter ADDR_W = 16
) (
    input wire              aclk,               // Bus clock
    input wire              aresetn,            // Reset, active low
    input wire              monitor_mode,       // Monitor mode
    input wire              cpu_trap_return,    // Trap return pulse
    input wire              breakpoint_request, // Trap request
    input wire [ADDR_W-1:0] break_vector,       // Trap vector
    input wire              break_state,        // Break in progress
    input wire              watchdog_hold,      // Watchdog held off
    input wire              timer_freeze,       // Timer stopped
    input wire              flag_clear_allow    // Flags clearable
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////
    a_req_pulse: assert property (breakpoint_request |=> !breakpoint_request)
        else $error("trap request wider than one cycle");
    a_req_state: assert property (breakpoint_request |-> $rose(break_state))
        else $error("trap request without break state rising");
    a_req_vector: assert property (breakpoint_request |->
        break_vector == (monitor_mode ? 16'hFEFC : 16'hFFFC)) else $error("wrong trap vector");
    a_break_end: assert property (break_state && cpu_trap_return |=> !break_state)
        else $error("break state kept after trap return");
    a_break_hold: assert property (break_state && !cpu_trap_return |=> break_state)
        else $error("break state dropped early");
    a_timer_stop: assert property (timer_freeze == break_state)
        else $error("timer freeze differs from break state");
    a_wdog_hold: assert property (watchdog_hold |-> break_state && monitor_mode)
        else $error("watchdog held outside monitor break");
    a_flag_free: assert property (!break_state [*2] |-> flag_clear_allow)
        else $error("flags locked outside break");
endmodule // bku_bp_asserts
bind bku_breakpoint_unit bku_bp_asserts #(.ADDR_W(ADDR_W)) i_chk (
    .aclk, .aresetn, .monitor_mode, .cpu_trap_return, .breakpoint_request, .break_vector,
    .break_state, .watchdog_hold, .timer_freeze, .flag_clear_allow
);

// file: bench/bku_cpu_model.sv
// CPU core and system integration model facing the breakpoint unit
`timescale 1ns/100ps
module bku_cpu_model (
    input  wire        aclk,               // Bus clock
    input  wire        aresetn,            // Reset, active low
    input  wire        run,                // Let the program advance
    input  wire        jump,               // Load a new program counter
    input  wire [15:0] jump_addr,          // Jump target
    input  wire        low_power,          // Wait or stop, bus frozen
    input  wire        svc_done,           // Break routine finished
    input  wire        breakpoint_request, // Trap request from the unit
    output reg  [15:0] cpu_addr,           // Address bus
    output reg         cpu_addr_is_pc,     // Fetch from program counter
    output reg         cpu_opcode_fetch,   // Even addresses hold opcodes
    output reg         cpu_insn_boundary,  // Opcode about to start
    output reg         cpu_trap_return     // Return from trap, pulse
);
    reg [15:0] pc;      // Program counter
    reg        in_trap; // Inside the break routine
    ////////////////////////////////
    // One byte a cycle; in the trap the bus shows changing non-program traffic
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc      <= 16'h0000;
            in_trap <= 1'b0;
        end
        else if (jump)
            pc <= jump_addr;
        else if (run && !in_trap && !low_power)
            pc <= pc + 16'h0001;
        if (aresetn && breakpoint_request)
            in_trap <= 1'b1;
        else if (aresetn && in_trap && svc_done)
            in_trap <= 1'b0;
        cpu_trap_return   <= aresetn && in_trap && svc_done;
        cpu_addr          <= in_trap ? ~cpu_addr : pc;
        cpu_addr_is_pc    <= !in_trap;
        cpu_opcode_fetch  <= !pc[0];
        cpu_insn_boundary <= run && !in_trap && !low_power && !pc[0];
    end
endmodule // bku_cpu_model

// file: bench/tb_top.sv
// Self-checking bench for the breakpoint unit
`timescale 1ns/100ps
`include "bku_consts.vh"
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin miscompares = miscompares + 1; \
$display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    localparam [1:0] rsp_ok = `BKU_RESP_OKAY;
    reg         aclk, aresetn, run, jump, svc_done, low_power, monitor_mode, wake;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    reg  [15:0] jump_addr;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] cpu_addr, break_vector;
    wire        cpu_addr_is_pc, cpu_opcode_fetch, cpu_insn_boundary, cpu_trap_return;
    wire        breakpoint_request, break_state, watchdog_hold, timer_freeze, flag_clear_allow, irq;
    integer     miscompares, cmp_count;
    ////////////////////////////////
    // Clock enable stays fixed; single-lane writes only
    bku_breakpoint_unit i_dut (
        .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu_addr, .cpu_addr_is_pc, .cpu_opcode_fetch, .cpu_insn_boundary,
        .cpu_trap_return, .cpu_low_power(low_power), .cpu_wait_wakeup(wake), .monitor_mode,
        .breakpoint_request, .break_vector, .break_state, .watchdog_hold, .timer_freeze,
        .flag_clear_allow, .irq
    );
    bku_cpu_model i_cpu (
        .aclk, .aresetn, .run, .jump, .jump_addr, .low_power, .svc_done, .breakpoint_request,
        .cpu_addr, .cpu_addr_is_pc, .cpu_opcode_fetch, .cpu_insn_boundary, .cpu_trap_return
    );
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////
    task final_report;
    begin
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // A bounded wait ran out: no point going on
    task lost;
    begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        final_report;
    end
    endtask
    // Write: address and data offered together, each dropped once taken
    task wr(input [7:0] a, input [7:0] d, input [1:0] er);
        integer n;
    begin
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n > 60) lost;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    end
    endtask
    // Read; data judged only on an OKAY answer
    task rd(input [7:0] a, input [7:0] ed, input [1:0] er);
        integer n;
    begin
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n > 60) lost;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er)
        if (er == rsp_ok) `CHK(s_axi_rdata, {24'h00_0000, ed})
    end
    endtask
    // Wait for the one-cycle trap request, or for the break to end
    task wait_bp(input end_wait);
        integer n;
    begin
        n = 0;
        do
        begin
            @(posedge aclk);
            n = n + 1;
            if (n > 80) lost;
        end
        while (end_wait ? break_state : !breakpoint_request);
    end
    endtask
    task no_req(input integer c);
        repeat (c) @(posedge aclk) `CHK(breakpoint_request, 1'b0)
    endtask
    // Jump the model's program counter and let it run
    task go(input [15:0] a);
    begin
        @(posedge aclk);
        jump      <= 1'b1;
        jump_addr <= a;
        run       <= 1'b1;
        @(posedge aclk);
        jump <= 1'b0;
    end
    endtask
    // End of the break routine: return from trap
    task finish_svc;
    begin
        @(posedge aclk);
        svc_done <= 1'b1;
        @(posedge aclk);
        svc_done <= 1'b0;
        wait_bp(1'b1);
    end
    endtask
    ////////////////////////////////
    task t_reset_vals;
        reg [7:0] a;
    begin
        for (a = 8'h00; a < 8'h20; a = a + 8'h04)
            rd(a, 8'h00, rsp_ok);
        rd(8'h24, 8'h00, `BKU_RESP_SLVERR);
        wr(8'h24, 8'hFF, `BKU_RESP_SLVERR);
        `CHK(break_vector, `BKU_VECTOR_NORMAL)
    end
    endtask
    // Match held off in low power, taken after; masked then enabled interrupt
    task t_addr_match;
    begin
        wr(`BKU_OFF_ADDR_HIGH, 8'h12, rsp_ok);
        wr(`BKU_OFF_ADDR_LOW, 8'h34, rsp_ok);
        rd(`BKU_OFF_ADDR_HIGH, 8'h12, rsp_ok);
        rd(`BKU_OFF_ADDR_LOW, 8'h34, rsp_ok);
        wr(`BKU_OFF_STATUS_CONTROL, 8'h80, rsp_ok);
        low_power <= 1'b1;
        go(16'h1234);
        no_req(30);
        low_power <= 1'b0;
        wait_bp(1'b0);
        `CHK(break_vector, `BKU_VECTOR_NORMAL)
        `CHK(irq, 1'b0)
        rd(`BKU_OFF_STATUS_CONTROL, 8'hC0, rsp_ok);
        rd(`BKU_OFF_IRQ_STATUS, 8'h01, rsp_ok);
        wr(`BKU_OFF_IRQ_ENABLE, 8'h03, rsp_ok);
        rd(`BKU_OFF_IRQ_ENABLE, 8'h03, rsp_ok);
        `CHK(irq, 1'b1)
        wr(`BKU_OFF_STATUS_CONTROL, 8'h80, rsp_ok);
        rd(`BKU_OFF_STATUS_CONTROL, 8'h80, rsp_ok);
        finish_svc;
        rd(`BKU_OFF_IRQ_STATUS, 8'h03, rsp_ok);
        wr(`BKU_OFF_IRQ_CLEAR, 8'h03, rsp_ok);
        rd(`BKU_OFF_IRQ_STATUS, 8'h00, rsp_ok);
        `CHK(irq, 1'b0)
        go(16'h1230);
        no_req(30);
        wr(`BKU_OFF_STATUS_CONTROL, 8'h00, rsp_ok);
    end
    endtask
    // Software-started break in monitor mode with watchdog suppress
    task t_soft_mon;
    begin
        monitor_mode <= 1'b1;
        wr(`BKU_OFF_AUXILIARY, 8'h01, rsp_ok);
        go(16'h2000);
        wr(`BKU_OFF_STATUS_CONTROL, 8'h40, rsp_ok);
        wait_bp(1'b0);
        wake <= 1'b1;
        @(posedge aclk) wake <= 1'b0;
        rd(`BKU_OFF_WAIT_STATUS, 8'h02, rsp_ok);
        `CHK(break_vector, `BKU_VECTOR_MONITOR)
        rd(`BKU_OFF_STATUS_CONTROL, 8'h40, rsp_ok);
        `CHK(watchdog_hold, 1'b1)
        `CHK(flag_clear_allow, 1'b0)
        wr(`BKU_OFF_FLAG_CONTROL, 8'h80, rsp_ok);
        rd(`BKU_OFF_FLAG_CONTROL, 8'h80, rsp_ok);
        `CHK(flag_clear_allow, 1'b1)
        wr(`BKU_OFF_STATUS_CONTROL, 8'h00, rsp_ok);
        finish_svc;
        rd(`BKU_OFF_STATUS_CONTROL, 8'h00, rsp_ok);
        `CHK(watchdog_hold, 1'b0)
        `CHK(timer_freeze, 1'b0)
    end
    endtask
    ////////////////////////////////
    initial
    begin
        {aresetn, run, jump, svc_done, low_power, monitor_mode, wake, jump_addr} = 23'h00_0000;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        miscompares = 0;
        cmp_count = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals;
        t_addr_match;
        t_soft_mon;
        final_report;
    end
endmodule // tb_top

// file: rtl/bku_addr_match.v
// Registered 16-bit program-address comparator with enable gating
`timescale 1ns/100ps
module bku_addr_match #(
    parameter ADDR_W = 16
) (
    input  wire              aclk,          // Bus clock
    input  wire              aresetn,       // Synchronous reset, active low
    input  wire              ce,            // Clock enable
    input  wire              enable,        // Compare enable
    input  wire              addr_valid,    // Address is CPU-generated and advancing
    input  wire [ADDR_W-1:0] cpu_addr,      // Program address
    input  wire [ADDR_W-1:0] break_addr,    // Stored compare value
    output reg               hit            // Match pulse
);
    // One-cycle hit, registered so the comparator stays off the critical path
    always @(posedge aclk)
    begin
        if (!aresetn)
            hit <= 1'b0;
        else if (ce)
            hit <= enable && addr_valid && (cpu_addr == break_addr);
    end
endmodule // bku_addr_match

// file: rtl/bku_breakpoint_unit.v
// Breakpoint unit: address match, software break, break state and AXI4-Lite registers
//
// Notes on behaviour
// - Enabled address match raises breakpoint request
// - Vector FFFC, or FEFC in monitor mode
// - Writing one to active starts break
// - Opcode match blocks instruction until service; code waits for the next instruction boundary as for any hit
// - Operand match lets instruction complete first
// - Return from trap ends break state
// - Bit 7 enables full 16-bit match
// - Active set on match, cleared by zero
// - Two address bytes, cleared by reset
// - Watchdog held off in monitor break; code holds it only when the auxiliary suppress bit is also set
// - Wait-exit bit shows break left wait
// - Flag clearing in break needs enable
// - No match while in wait or stop
// - Timer stopped, captures inhibited during break
// - No rebreak when active cleared, address same
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "bku_consts.vh"
module bku_breakpoint_unit #(
    parameter ADDR_W = 16
) (
    input  wire              aclk,              // Bus clock
    input  wire              aresetn,           // Synchronous reset, active low
    input  wire              ce,                // Clock enable, freezes all state when low
    // AXI4-Lite slave
    input  wire [7:0]        s_axi_awaddr,      // Write address
    input  wire              s_axi_awvalid,     // Write address valid
    output reg               s_axi_awready,     // Write address ready
    input  wire [31:0]       s_axi_wdata,       // Write data
    input  wire [3:0]        s_axi_wstrb,       // Write strobes
    input  wire              s_axi_wvalid,      // Write data valid
    output reg               s_axi_wready,      // Write data ready
    output reg  [1:0]        s_axi_bresp,       // Write response
    output reg               s_axi_bvalid,      // Write response valid
    input  wire              s_axi_bready,      // Write response ready
    input  wire [7:0]        s_axi_araddr,      // Read address
    input  wire              s_axi_arvalid,     // Read address valid
    output reg               s_axi_arready,     // Read address ready
    output reg  [31:0]       s_axi_rdata,       // Read data
    output reg  [1:0]        s_axi_rresp,       // Read response
    output reg               s_axi_rvalid,      // Read data valid
    input  wire              s_axi_rready,      // Read data ready
    // CPU core and system integration side
    input  wire [ADDR_W-1:0] cpu_addr,          // Internal address bus
    input  wire              cpu_addr_is_pc,    // Address is a program-counter fetch
    input  wire              cpu_opcode_fetch,  // Fetch is an opcode, not an operand
    input  wire              cpu_insn_boundary, // Next instruction about to begin
    input  wire              cpu_trap_return,   // Return from trap executed
    input  wire              cpu_low_power,     // Wait or stop mode
    input  wire              cpu_wait_wakeup,   // Wait mode left on this cycle
    input  wire              monitor_mode,      // Part in monitor mode
    output reg               breakpoint_request,// Force soft trap opcode, pulse
    output reg  [ADDR_W-1:0] break_vector,      // Vector address for the trap
    output reg               break_state,       // Break in progress
    output reg               watchdog_hold,     // Disable watchdog timer
    output reg               timer_freeze,      // Stop timer counter, block captures
    output reg               flag_clear_allow,  // Module status bits clearable
    output reg               irq                // Level interrupt
);
    localparam ST_IDLE = 3'b001;
    localparam ST_PEND = 3'b010;
    localparam ST_BRK  = 3'b100;

    reg [2:0]        state;
    reg [2:0]        next_state;
    reg              break_match_enable;
    reg              break_active_flag;
    reg [7:0]        break_address_high;
    reg [7:0]        break_address_low;
    reg              break_watchdog_suppress;
    reg              wait_exit_by_break;
    reg              break_flag_clear_enable;
    reg [1:0]        irq_status;
    reg [1:0]        irq_enable;
    reg              addr_spent;
    reg              aw_held;
    reg              w_held;
    reg [7:0]        aw_addr;
    reg [31:0]       w_data;
    reg [3:0]        w_strb;
    reg [31:0]       rd_word;
    reg              rd_hit;
    wire             hit;
    wire             wr_go;
    wire             wr_lane0;
    wire             wr_known;
    wire [ADDR_W-1:0] break_addr;

    // Write data lane zero written on the current commit
    function lane0_write;
        input [7:0] a;
        input [7:0] off;
        input       go;
        input       strb0;
        begin
            lane0_write = go && strb0 && (a == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address comparison
    assign break_addr = {break_address_high, break_address_low};
    // Stalled address in low power never counts as a new fetch
    bku_addr_match #(
        .ADDR_W     (ADDR_W)
    ) u_match (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .enable     (break_match_enable && !break_active_flag && !addr_spent),
        .addr_valid (cpu_addr_is_pc && !cpu_low_power),
        .cpu_addr   (cpu_addr),
        .break_addr (break_addr),
        .hit        (hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order
    assign wr_go    = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = w_strb[0];
    assign wr_known = (aw_addr == `BKU_OFF_STATUS_CONTROL) || (aw_addr == `BKU_OFF_ADDR_HIGH)
                   || (aw_addr == `BKU_OFF_ADDR_LOW) || (aw_addr == `BKU_OFF_AUXILIARY)
                   || (aw_addr == `BKU_OFF_WAIT_STATUS) || (aw_addr == `BKU_OFF_FLAG_CONTROL)
                   || (aw_addr == `BKU_OFF_IRQ_STATUS) || (aw_addr == `BKU_OFF_IRQ_ENABLE)
                   || (aw_addr == `BKU_OFF_IRQ_CLEAR);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BKU_RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `BKU_RESP_OKAY : `BKU_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one-cycle decode, data registered with rvalid
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `BKU_OFF_STATUS_CONTROL:
            begin
                rd_word[`BKU_BIT_MATCH_ENABLE] = break_match_enable;
                rd_word[`BKU_BIT_ACTIVE]       = break_active_flag;
            end
            `BKU_OFF_ADDR_HIGH:    rd_word[7:0] = break_address_high;
            `BKU_OFF_ADDR_LOW:     rd_word[7:0] = break_address_low;
            `BKU_OFF_AUXILIARY:    rd_word[`BKU_BIT_WDOG_SUPPRESS] = break_watchdog_suppress;
            `BKU_OFF_WAIT_STATUS:  rd_word[`BKU_BIT_WAIT_EXIT] = wait_exit_by_break;
            `BKU_OFF_FLAG_CONTROL: rd_word[`BKU_BIT_FLAG_CLEAR] = break_flag_clear_enable;
            `BKU_OFF_IRQ_STATUS:   rd_word[1:0] = irq_status;
            `BKU_OFF_IRQ_ENABLE:   rd_word[1:0] = irq_enable;
            `BKU_OFF_IRQ_CLEAR:    rd_word = 32'h0000_0000;
            default:               rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BKU_RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `BKU_RESP_OKAY : `BKU_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; only byte lane zero carries data
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            break_match_enable      <= 1'b0;
            break_address_high      <= `BKU_RESET_BYTE;
            break_address_low       <= `BKU_RESET_BYTE;
            break_watchdog_suppress <= 1'b0;
            break_flag_clear_enable <= 1'b0;
            irq_enable              <= 2'b00;
        end
        else if (ce)
        begin
            if (lane0_write(aw_addr, `BKU_OFF_STATUS_CONTROL, wr_go, wr_lane0))
                break_match_enable <= w_data[`BKU_BIT_MATCH_ENABLE];
            if (lane0_write(aw_addr, `BKU_OFF_ADDR_HIGH, wr_go, wr_lane0))
                break_address_high <= w_data[7:0];
            if (lane0_write(aw_addr, `BKU_OFF_ADDR_LOW, wr_go, wr_lane0))
                break_address_low <= w_data[7:0];
            if (lane0_write(aw_addr, `BKU_OFF_AUXILIARY, wr_go, wr_lane0))
                break_watchdog_suppress <= w_data[`BKU_BIT_WDOG_SUPPRESS];
            if (lane0_write(aw_addr, `BKU_OFF_FLAG_CONTROL, wr_go, wr_lane0))
                break_flag_clear_enable <= w_data[`BKU_BIT_FLAG_CLEAR];
            if (lane0_write(aw_addr, `BKU_OFF_IRQ_ENABLE, wr_go, wr_lane0))
                irq_enable <= w_data[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break active flag: a match sets it, and a set beats a software clear
    // A hit spends its address until software moves it, so one break cannot repeat
    wire sw_ctl_write = lane0_write(aw_addr, `BKU_OFF_STATUS_CONTROL, wr_go, wr_lane0);
    wire sw_start     = sw_ctl_write && w_data[`BKU_BIT_ACTIVE] && !break_active_flag;
    wire addr_wr      = lane0_write(aw_addr, `BKU_OFF_ADDR_HIGH, wr_go, wr_lane0)
                     || lane0_write(aw_addr, `BKU_OFF_ADDR_LOW, wr_go, wr_lane0);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            break_active_flag <= 1'b0;
            addr_spent        <= 1'b0;
        end
        else if (ce)
        begin
            addr_spent <= hit || (addr_spent && !addr_wr);
            if (hit || sw_start)
                break_active_flag <= 1'b1;
            else if (sw_ctl_write && !w_data[`BKU_BIT_ACTIVE])
                break_active_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break sequencing: pending until the right instruction boundary
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (hit || sw_start)
                    next_state = ST_PEND;
            ST_PEND:
                // Opcode, operand and software hits all wait for the next instruction
                // boundary; cpu_opcode_fetch is not used
                if (cpu_insn_boundary)
                    next_state = ST_BRK;
            ST_BRK:
                if (cpu_trap_return)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state              <= ST_IDLE;
            breakpoint_request <= 1'b0;
            break_vector       <= `BKU_VECTOR_NORMAL;
            break_state        <= 1'b0;
            watchdog_hold      <= 1'b0;
            timer_freeze       <= 1'b0;
            flag_clear_allow   <= 1'b1;
        end
        else if (ce)
        begin
            state <= next_state;
            // Request held as a pulse when the trap opcode is to be loaded
            breakpoint_request <= (state == ST_PEND) && (next_state == ST_BRK);
            break_vector <= monitor_mode ? `BKU_VECTOR_MONITOR : `BKU_VECTOR_NORMAL;
            break_state  <= (next_state == ST_BRK);
            watchdog_hold <= (next_state == ST_BRK) && monitor_mode && break_watchdog_suppress;
            timer_freeze  <= (next_state == ST_BRK);
            flag_clear_allow <= (next_state != ST_BRK) || break_flag_clear_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait-exit status: remembers that a break woke the part from wait
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wait_exit_by_break <= 1'b0;
        end
        else if (ce)
        begin
            if (cpu_wait_wakeup && (state != ST_IDLE || sw_start))
                wait_exit_by_break <= 1'b1;
            else if (cpu_wait_wakeup || cpu_trap_return)
                wait_exit_by_break <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: start and end of break; set wins over clear
    wire irq_clr_wr = lane0_write(aw_addr, `BKU_OFF_IRQ_CLEAR, wr_go, wr_lane0);
    wire [1:0] irq_set = {(state == ST_BRK) && cpu_trap_return, breakpoint_request};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 2'b00;
            irq        <= 1'b0;
        end
        else if (ce)
        begin
            irq_status <= irq_set | (irq_status & ~(irq_clr_wr ? w_data[1:0] : 2'b00));
            irq        <= |(irq_status & irq_enable);
        end
    end
endmodule // bku_breakpoint_unit

// file: rtl/bku_consts.vh
// Register map, field positions, reset values and vectors of the breakpoint unit
`ifndef BKU_CONSTS_VH
`define BKU_CONSTS_VH
`define BKU_OFF_STATUS_CONTROL  8'h00
`define BKU_OFF_ADDR_HIGH       8'h04
`define BKU_OFF_ADDR_LOW        8'h08
`define BKU_OFF_AUXILIARY       8'h0C
`define BKU_OFF_WAIT_STATUS     8'h10
`define BKU_OFF_FLAG_CONTROL    8'h14
`define BKU_OFF_IRQ_STATUS      8'h18
`define BKU_OFF_IRQ_ENABLE      8'h1C
`define BKU_OFF_IRQ_CLEAR       8'h20
`define BKU_BIT_MATCH_ENABLE    7
`define BKU_BIT_ACTIVE          6
`define BKU_BIT_WDOG_SUPPRESS   0
`define BKU_BIT_WAIT_EXIT       1
`define BKU_BIT_FLAG_CLEAR      7
`define BKU_IRQ_BIT_START       0
`define BKU_IRQ_BIT_END         1
`define BKU_RESET_BYTE          8'h00
`define BKU_VECTOR_NORMAL       16'hFFFC
`define BKU_VECTOR_MONITOR      16'hFEFC
`define BKU_RESP_OKAY           2'b00
`define BKU_RESP_SLVERR         2'b10
`endif
